//--- rtl/pin_edge_detect.sv
// Three-stage pin synchroniser with either-edge pulse
`timescale 1ns/100ps
module pin_edge_detect #(
    parameter int STAGES = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pin and pulse
    input wire logic pin,
    output logic edge_pulse
);
    logic [STAGES-1:0] sync_reg;
    logic [STAGES-1:0] sync_next;
    logic level_reg;
    logic level_next;
    logic prime_reg;
    logic prime_next;
    logic [STAGES-1:0] fill_reg;
    logic [STAGES-1:0] fill_next;

    always_comb begin
        sync_next = {sync_reg[STAGES-2:0], pin};
        level_next = level_reg;
        fill_next = {fill_reg[STAGES-2:0], 1'b1};
        // Reset zeros in the chain are no pin level, so stay blind until it refills
        prime_next = fill_reg[STAGES-1];
        edge_pulse = 1'b0;
        // Change counts once the last two stages agree
        if (sync_reg[STAGES-1] == sync_reg[STAGES-2]) begin
            level_next = sync_reg[STAGES-1];
            edge_pulse = prime_reg && (sync_reg[STAGES-1] != level_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_reg <= '0;
            level_reg <= 1'b0;
            prime_reg <= 1'b0;
            fill_reg <= '0;
        end else begin
            sync_reg <= sync_next;
            level_reg <= level_next;
            prime_reg <= prime_next;
            fill_reg <= fill_next;
        end
    end
endmodule : pin_edge_detect

//--- rtl/runtime_misc_floppy_regs.sv
// Runtime edge status, force media change and rate shadow register bank
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module runtime_misc_floppy_regs (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Register port
    input wire logic [misc_regs_pkg::ADDR_W-1:0] ADDR,
    input wire logic [misc_regs_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [misc_regs_pkg::DATA_W-1:0] RDATA,
    // Monitored pins
    input wire logic [misc_regs_pkg::NUM_PINS-1:0] MONITORED_PIN,
    input wire logic MONITORED_PIN_5_ALT,
    input wire logic PIN5_ALT_SELECT,
    // Floppy drive signals
    input wire logic HEAD_STEP_PULSE_N,
    input wire logic DRIVE_SELECT_0_N,
    input wire logic DRIVE_SELECT_1_N,
    input wire logic MEDIA_CHANGED_IN_N,
    // Data-rate-select write from the floppy controller
    input wire logic RATE_WR,
    input wire logic [misc_regs_pkg::DATA_W-1:0] RATE_WDATA,
    // Outputs
    output logic MEDIA_CHANGED_FLAG,
    output logic IRQ
);
    import misc_regs_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_src;
    logic [NUM_PINS-1:0] pin_edge;
    logic [2:0] step_sync_reg;
    logic [2:0] step_sync_next;
    logic [2:0] ds0_sync_reg;
    logic [2:0] ds0_sync_next;
    logic [2:0] ds1_sync_reg;
    logic [2:0] ds1_sync_next;
    logic [2:0] chg_sync_reg;
    logic [2:0] chg_sync_next;
    logic step_lvl_reg;
    logic step_lvl_next;
    logic ds0_lvl_reg;
    logic ds0_lvl_next;
    logic ds1_lvl_reg;
    logic ds1_lvl_next;
    logic chg_lvl_reg;
    logic chg_lvl_next;
    logic step_fall;

    // Alternate pin choice for bit 5 is left to the integrator
    always_comb begin
        pin_src = MONITORED_PIN;
        pin_src[5] = PIN5_ALT_SELECT ? MONITORED_PIN_5_ALT : MONITORED_PIN[5];
    end

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        pin_edge_detect #(
            .STAGES(SYNC_STAGES)
        ) u_edge (
            .clk(CLK),
            .srst(SRST),
            .pin(pin_src[i]),
            .edge_pulse(pin_edge[i])
        );
    end

    // ------------------------------------------------------------------------
    // Drive signal synchronisers
    // ------------------------------------------------------------------------
    always_comb begin
        step_sync_next = {step_sync_reg[1:0], HEAD_STEP_PULSE_N};
        ds0_sync_next = {ds0_sync_reg[1:0], DRIVE_SELECT_0_N};
        ds1_sync_next = {ds1_sync_reg[1:0], DRIVE_SELECT_1_N};
        chg_sync_next = {chg_sync_reg[1:0], MEDIA_CHANGED_IN_N};
        step_lvl_next = (step_sync_reg[2] == step_sync_reg[1]) ? step_sync_reg[2] : step_lvl_reg;
        ds0_lvl_next = (ds0_sync_reg[2] == ds0_sync_reg[1]) ? ds0_sync_reg[2] : ds0_lvl_reg;
        ds1_lvl_next = (ds1_sync_reg[2] == ds1_sync_reg[1]) ? ds1_sync_reg[2] : ds1_lvl_reg;
        chg_lvl_next = (chg_sync_reg[2] == chg_sync_reg[1]) ? chg_sync_reg[2] : chg_lvl_reg;
        // Step is active low: falling level starts a pulse
        step_fall = step_lvl_reg && !step_lvl_next;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            step_sync_reg <= 3'h7;
            ds0_sync_reg <= 3'h7;
            ds1_sync_reg <= 3'h7;
            chg_sync_reg <= 3'h7;
            step_lvl_reg <= 1'b1;
            ds0_lvl_reg <= 1'b1;
            ds1_lvl_reg <= 1'b1;
            chg_lvl_reg <= 1'b1;
        end else begin
            step_sync_reg <= step_sync_next;
            ds0_sync_reg <= ds0_sync_next;
            ds1_sync_reg <= ds1_sync_next;
            chg_sync_reg <= chg_sync_next;
            step_lvl_reg <= step_lvl_next;
            ds0_lvl_reg <= ds0_lvl_next;
            ds1_lvl_reg <= ds1_lvl_next;
            chg_lvl_reg <= chg_lvl_next;
        end
    end

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [5:0] status_reg;
    logic [5:0] status_next;
    logic [1:0] force_reg;
    logic [1:0] force_next;
    logic [7:0] shadow_reg;
    logic [7:0] shadow_next;
    logic [5:0] irq_en_reg;
    logic [5:0] irq_en_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [5:0] status_clr;
    logic [1:0] force_clr;

    always_comb begin
        status_clr = '0;
        if (WR && (ADDR == OFS_EDGE_STATUS || ADDR == OFS_IRQ_CLEAR)) begin
            status_clr = WDATA[5:0];
        end
        // Set wins over a clear in the same cycle
        status_next = (status_reg & ~status_clr) | pin_edge[5:0];

        // Hardware clear on a step pulse of the selected drive
        force_clr[0] = step_fall && !ds0_lvl_reg;
        force_clr[1] = step_fall && !ds1_lvl_reg;
        force_next = force_reg & ~force_clr;
        if (WR && ADDR == OFS_FORCE_CHANGE) begin
            force_next = force_next | WDATA[1:0];
        end

        shadow_next = shadow_reg;
        if (RATE_WR) begin
            shadow_next = RATE_WDATA & RATE_SHADOW_MASK;
        end

        irq_en_next = irq_en_reg;
        if (WR && ADDR == OFS_IRQ_ENABLE) begin
            irq_en_next = WDATA[5:0];
        end

        rdata_next = 8'h00;
        if (RD) begin
            unique case (ADDR)
                OFS_EDGE_STATUS: rdata_next = {2'h0, status_reg};
                OFS_RESERVED: rdata_next = 8'h00;
                OFS_FORCE_CHANGE: rdata_next = {6'h00, force_reg};
                OFS_RATE_SHADOW: rdata_next = shadow_reg;
                OFS_IRQ_ENABLE: rdata_next = {2'h0, irq_en_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            status_reg <= RST_EDGE_STATUS;
            force_reg <= RST_FORCE_CHANGE;
            shadow_reg <= RST_RATE_SHADOW;
            irq_en_reg <= RST_IRQ_ENABLE;
            rdata_reg <= 8'h00;
        end else begin
            status_reg <= status_next;
            force_reg <= force_next;
            shadow_reg <= shadow_next;
            irq_en_reg <= irq_en_next;
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA = rdata_reg;
    assign IRQ = |(status_reg & irq_en_reg);
    // Select lines are active low, hence the inversion
    assign MEDIA_CHANGED_FLAG = (!ds0_lvl_reg && force_reg[0]) || (!ds1_lvl_reg && force_reg[1])
        || !chg_lvl_reg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_force_write;
        WR && ADDR == OFS_FORCE_CHANGE && WDATA[0] && !force_clr[0];
    endsequence

    sequence s_force_write_1;
        WR && ADDR == OFS_FORCE_CHANGE && WDATA[1] && !force_clr[1];
    endsequence

    // A zero written over a set force bit with no step pending
    sequence s_force_zero_write;
        WR && ADDR == OFS_FORCE_CHANGE && !WDATA[0] && force_reg[0] && !force_clr[0];
    endsequence

    sequence s_status_keep;
        status_reg[0] && !(WR && (ADDR == OFS_EDGE_STATUS || ADDR == OFS_IRQ_CLEAR) && WDATA[0]);
    endsequence

    sequence s_status_idle;
        !pin_edge[4] && !(WR && (ADDR == OFS_EDGE_STATUS || ADDR == OFS_IRQ_CLEAR));
    endsequence

    // No second controller load may fall between the load and the read
    sequence s_rate_load;
        RATE_WR ##1 !RATE_WR;
    endsequence

    sequence s_shadow_read;
        RD && ADDR == OFS_RATE_SHADOW && !RATE_WR;
    endsequence

    sequence s_reset_release;
        SRST ##1 !SRST;
    endsequence

    AST_EDGE_SETS: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[0] |=> status_reg[0]) else $error("edge did not set status bit 0");
    AST_EDGE_SETS_MID: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[3] |=> status_reg[3]) else $error("edge did not set status bit 3");
    AST_EDGE_SETS_TOP: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[5] |=> status_reg[5]) else $error("edge did not set status bit 5");
    AST_W1C: assert property (@(posedge CLK) disable iff (SRST)
        WR && ADDR == OFS_EDGE_STATUS && WDATA[1] && !pin_edge[1] |=> !status_reg[1])
        else $error("write one did not clear status bit 1");
    AST_RSVD_ZERO: assert property (@(posedge CLK) disable iff (SRST)
        RD && ADDR == OFS_EDGE_STATUS |=> RDATA[7:6] == 2'h0) else $error("status upper bits not zero");
    AST_RSVD_LOC: assert property (@(posedge CLK) disable iff (SRST)
        RD && ADDR == OFS_RESERVED |=> RDATA == 8'h00) else $error("reserved location not zero");
    AST_FORCE_SET: assert property (@(posedge CLK) disable iff (SRST)
        s_force_write |=> force_reg[0]) else $error("force bit 0 not set by write");
    AST_FORCE_CLR0: assert property (@(posedge CLK) disable iff (SRST)
        force_clr[0] && !(WR && ADDR == OFS_FORCE_CHANGE) |=> !force_reg[0])
        else $error("force bit 0 not cleared by step");
    AST_FORCE_CLR1: assert property (@(posedge CLK) disable iff (SRST)
        force_clr[1] && !(WR && ADDR == OFS_FORCE_CHANGE) |=> !force_reg[1])
        else $error("force bit 1 not cleared by step");
    AST_FLAG: assert property (@(posedge CLK) disable iff (SRST)
        !chg_lvl_reg |-> MEDIA_CHANGED_FLAG) else $error("media changed input not reported");
    AST_RESET_FORCE: assert property (@(posedge CLK)
        SRST |=> force_reg == RST_FORCE_CHANGE) else $error("force register reset wrong");

    AST_SHADOW: assert property (@(posedge CLK) disable iff (SRST)
        s_rate_load ##1 s_shadow_read |=> RDATA == ($past(RATE_WDATA, 3) & RATE_SHADOW_MASK))
        else $error("shadow readback wrong");
    AST_SHADOW_RSVD: assert property (@(posedge CLK) disable iff (SRST)
        RD && ADDR == OFS_RATE_SHADOW |=> !RDATA[5]) else $error("shadow reserved bit not zero");
    AST_SHADOW_HOLD: assert property (@(posedge CLK) disable iff (SRST)
        !RATE_WR |=> $stable(shadow_reg)) else $error("shadow changed without a controller load");

    AST_EDGE_SETS_1: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[1] |=> status_reg[1]) else $error("edge did not set status bit 1");
    AST_EDGE_SETS_2: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[2] |=> status_reg[2]) else $error("edge did not set status bit 2");
    AST_EDGE_SETS_4: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[4] |=> status_reg[4]) else $error("edge did not set status bit 4");
    AST_EDGE_ONE_CYCLE: assert property (@(posedge CLK) disable iff (SRST)
        pin_edge[2] |=> !pin_edge[2]) else $error("edge pulse longer than one clock");
    // A pin held high through reset must not look like an edge
    AST_QUIET_AFTER_RESET: assert property (@(posedge CLK)
        s_reset_release |-> (pin_edge == 6'h00) [*4]) else $error("false edge after reset");

    AST_W1C_KEEP: assert property (@(posedge CLK) disable iff (SRST)
        s_status_keep |=> status_reg[0]) else $error("status bit 0 lost without a clear");
    AST_STATUS_HOLD: assert property (@(posedge CLK) disable iff (SRST)
        s_status_idle |=> $stable(status_reg[4])) else $error("status bit 4 changed without cause");
    AST_CLEAR_ALIAS: assert property (@(posedge CLK) disable iff (SRST)
        WR && ADDR == OFS_IRQ_CLEAR && WDATA[2] && !pin_edge[2] |=> !status_reg[2])
        else $error("clear location did not clear status bit 2");

    AST_FORCE_SET1: assert property (@(posedge CLK) disable iff (SRST)
        s_force_write_1 |=> force_reg[1]) else $error("force bit 1 not set by write");
    AST_FORCE_KEEP: assert property (@(posedge CLK) disable iff (SRST)
        s_force_zero_write |=> force_reg[0]) else $error("force bit 0 cleared by a zero write");
    AST_FORCE_RSVD: assert property (@(posedge CLK) disable iff (SRST)
        RD && ADDR == OFS_FORCE_CHANGE |=> RDATA[7:2] == 6'h00) else $error("force upper bits not zero");
    AST_FORCE_HOLD0: assert property (@(posedge CLK) disable iff (SRST)
        force_reg[0] && !step_fall |=> force_reg[0]) else $error("force bit 0 cleared without a step");
    AST_FORCE_HOLD1: assert property (@(posedge CLK) disable iff (SRST)
        force_reg[1] && !step_fall |=> force_reg[1]) else $error("force bit 1 cleared without a step");
    AST_FORCE_OTHER0: assert property (@(posedge CLK) disable iff (SRST)
        force_reg[0] && ds0_lvl_reg |=> force_reg[0]) else $error("force bit 0 cleared while unselected");
    AST_FORCE_OTHER1: assert property (@(posedge CLK) disable iff (SRST)
        force_reg[1] && ds1_lvl_reg |=> force_reg[1]) else $error("force bit 1 cleared while unselected");

    AST_FLAG_DRIVE0: assert property (@(posedge CLK) disable iff (SRST)
        !ds0_lvl_reg && force_reg[0] |-> MEDIA_CHANGED_FLAG)
        else $error("forced change on drive 0 not reported");
    AST_FLAG_DRIVE1: assert property (@(posedge CLK) disable iff (SRST)
        !ds1_lvl_reg && force_reg[1] |-> MEDIA_CHANGED_FLAG)
        else $error("forced change on drive 1 not reported");
    AST_FLAG_IDLE: assert property (@(posedge CLK) disable iff (SRST)
        ds0_lvl_reg && ds1_lvl_reg && chg_lvl_reg |-> !MEDIA_CHANGED_FLAG)
        else $error("media change flag without cause");
endmodule : runtime_misc_floppy_regs

//--- shared/misc_regs_pkg.sv
// Constants shared by the runtime miscellaneous and floppy register bank
// ----------------------------------------------------------------------------
// Overview of operation
// - Status bits 0 and 1 set on any edge of monitored pins 0 and 1.
// - Status bits 2, 3 and 4 set on any edge of monitored pins 2, 3 and 4.
// - Status bit 5 sets on any edge of monitored pin 5, or of its alternate when selected.
// - Writing one to status bits 5..0 clears them and writing zero leaves them alone.
// - Status bits 7..6 always read as zero.
// - The location after the status register is read-only and reads zero.
// - Writing one sets a force-change bit and writing zero never clears it.
// - Force bit 0 is cleared by a step pulse while drive 0 is selected.
// - Force bit 1 is cleared by a step pulse while drive 1 is selected.
// - The media-changed flag is select-0 and force 0, or select-1 and force 1, or the drive input.
// - The force-change register resets to 0x03 on every reset.
// - A read-only shadow returns rate, precompensation, power-down in bit 6 and soft reset.
// ----------------------------------------------------------------------------
package misc_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 6;
    localparam logic [7:0] OFS_EDGE_STATUS = 8'h1C;
    localparam logic [7:0] OFS_RESERVED = 8'h1D;
    localparam logic [7:0] OFS_FORCE_CHANGE = 8'h1E;
    localparam logic [7:0] OFS_RATE_SHADOW = 8'h1F;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h30;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h31;
    localparam logic [5:0] RST_EDGE_STATUS = 6'h00;
    localparam logic [1:0] RST_FORCE_CHANGE = 2'h3;
    localparam logic [7:0] RST_RATE_SHADOW = 8'h00;
    localparam logic [5:0] RST_IRQ_ENABLE = 6'h00;
    localparam int POS_DRATE = 0;
    localparam int POS_WRITE_SELECT_A = 2;
    localparam int POS_POWER_DOWN = 6;
    localparam int POS_SOFT_RESET = 7;
    localparam logic [7:0] RATE_SHADOW_MASK = 8'hDF;
    localparam int SYNC_STAGES = 3;
endpackage : misc_regs_pkg

//--- testbench/drive_pin_model.sv
// Behavioural floppy drive and monitored pin model
`timescale 1ns/100ps
module drive_pin_model (
    // Clock
    input wire logic clk,
    // Drive and pin levels
    output logic step_n,
    output logic ds0_n,
    output logic ds1_n,
    output logic media_n,
    output logic [5:0] pins,
    output logic pin5_alt
);
    initial begin
        {step_n, ds0_n, ds1_n, media_n, pins, pin5_alt} = 11'h780;
    end
    task automatic toggle_pin(input int i);
        @(posedge clk);
        if (i == 6) begin
            pin5_alt <= ~pin5_alt;
        end else begin
            pins[i] <= ~pins[i];
        end
    endtask : toggle_pin
    // Levels then a wait long enough for the synchronisers
    task automatic set_drive(input logic [2:0] lv);
        @(posedge clk);
        {media_n, ds1_n, ds0_n} <= lv;
        repeat (6) @(posedge clk);
    endtask : set_drive
    // Four clocks low so the step is never lost in synchronising
    task automatic pulse_step();
        @(posedge clk);
        step_n <= 1'b0;
        repeat (4) @(posedge clk);
        step_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : pulse_step
endmodule : drive_pin_model

//--- testbench/runtime_misc_floppy_regs_tb.sv
// Self-checking bench for the runtime miscellaneous and floppy register bank
`timescale 1ns/100ps
module runtime_misc_floppy_regs_tb;
    import misc_regs_pkg::*;
    logic clk, srst, wr, rd, alt_sel, rate_wr;
    logic [7:0] addr, wdata, rdata, rate_wdata, got, b;
    logic step_n, ds0_n, ds1_n, media_n, pin5_alt, flag, irq;
    logic [5:0] pins;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    runtime_misc_floppy_regs DUT (
        .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .MONITORED_PIN(pins), .MONITORED_PIN_5_ALT(pin5_alt), .PIN5_ALT_SELECT(alt_sel),
        .HEAD_STEP_PULSE_N(step_n), .DRIVE_SELECT_0_N(ds0_n), .DRIVE_SELECT_1_N(ds1_n),
        .MEDIA_CHANGED_IN_N(media_n), .RATE_WR(rate_wr), .RATE_WDATA(rate_wdata),
        .MEDIA_CHANGED_FLAG(flag), .IRQ(irq)
    );
    drive_pin_model pm (
        .clk(clk), .step_n(step_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .media_n(media_n),
        .pins(pins), .pin5_alt(pin5_alt)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // Bus tasks and reporting
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    // Read data stand only in the cycle after the strobe
    task automatic exp_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
        check($sformatf("reg %h", a), got, exp);
    endtask : exp_reg
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {srst, wr, rd, alt_sel, rate_wr, addr, wdata, rate_wdata} = {1'b1, 28'h0};
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        exp_reg(OFS_FORCE_CHANGE, 8'h03);
        exp_reg(OFS_EDGE_STATUS, 8'h00);
        reg_wr(OFS_RESERVED, 8'hFF);
        exp_reg(OFS_RESERVED, 8'h00);
        exp_reg(8'h40, 8'h00);
        reg_wr(OFS_IRQ_ENABLE, 8'h3F);
        // Both edges of every pin, clear by either clear location
        for (int i = 0; i < 6; i++) begin
            b = 8'h01 << i;
            pm.toggle_pin(i);
            repeat (8) @(posedge clk);
            exp_reg(OFS_EDGE_STATUS, b);
            check("irq", {7'h00, irq}, 8'h01);
            reg_wr(OFS_EDGE_STATUS, ~b);
            reg_wr(OFS_IRQ_ENABLE, ~b);
            exp_reg(OFS_EDGE_STATUS, b);
            check("irq masked", {7'h00, irq}, 8'h00);
            reg_wr(OFS_IRQ_ENABLE, 8'h3F);
            reg_wr(OFS_EDGE_STATUS, b);
            exp_reg(OFS_EDGE_STATUS, 8'h00);
            check("irq clear", {7'h00, irq}, 8'h00);
            pm.toggle_pin(i);
            repeat (8) @(posedge clk);
            exp_reg(OFS_EDGE_STATUS, b);
            reg_wr(OFS_IRQ_CLEAR, b);
            exp_reg(OFS_EDGE_STATUS, 8'h00);
        end
        @(posedge clk);
        alt_sel <= 1'b1;
        pm.toggle_pin(5);
        repeat (8) @(posedge clk);
        exp_reg(OFS_EDGE_STATUS, 8'h00);
        pm.toggle_pin(6);
        repeat (8) @(posedge clk);
        exp_reg(OFS_EDGE_STATUS, 8'h20);
        // Force media change bits against step and selects
        reg_wr(OFS_FORCE_CHANGE, 8'h00);
        exp_reg(OFS_FORCE_CHANGE, 8'h03);
        pm.set_drive(3'b110);
        check("flag", {7'h00, flag}, 8'h01);
        pm.pulse_step();
        exp_reg(OFS_FORCE_CHANGE, 8'h02);
        check("flag", {7'h00, flag}, 8'h00);
        reg_wr(OFS_FORCE_CHANGE, 8'h01);
        exp_reg(OFS_FORCE_CHANGE, 8'h03);
        check("flag", {7'h00, flag}, 8'h01);
        pm.set_drive(3'b101);
        pm.pulse_step();
        exp_reg(OFS_FORCE_CHANGE, 8'h01);
        check("flag", {7'h00, flag}, 8'h00);
        pm.set_drive(3'b001);
        check("flag", {7'h00, flag}, 8'h01);
        reg_wr(OFS_FORCE_CHANGE, 8'h02);
        exp_reg(OFS_FORCE_CHANGE, 8'h03);
        // Rate shadow follows the controller write only
        @(posedge clk);
        rate_wr <= 1'b1;
        rate_wdata <= 8'hFF;
        @(posedge clk);
        rate_wr <= 1'b0;
        exp_reg(OFS_RATE_SHADOW, 8'hDF);
        reg_wr(OFS_RATE_SHADOW, 8'h00);
        exp_reg(OFS_RATE_SHADOW, 8'hDF);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        exp_reg(OFS_FORCE_CHANGE, 8'h03);
        // Bit 5 source sits high through this reset: no edge may be seen
        repeat (4) @(posedge clk);
        exp_reg(OFS_EDGE_STATUS, 8'h00);
        stop_test();
    end
endmodule : runtime_misc_floppy_regs_tb
